// File: include/sfr_pkg.sv
// Package: opcodes, phase lengths, pin layout and states of the serial flash read engine
package sfr_pkg;
   localparam logic [7:0] OP_NORMAL_READ = 8'h03;
   localparam logic [7:0] OP_NORMAL_READ_WIDE = 8'h13;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_FAST_READ_WIDE = 8'h0C;
   localparam logic [7:0] OP_QUAD_IO_FAST_READ = 8'hEB;
   localparam logic [7:0] OP_UNIQUE_ID_READ = 8'h4B;
   localparam logic [7:0] OP_INFO_ROW_READ = 8'h68;
   localparam logic [7:0] OP_ENTER_WIDE_ADDR = 8'hB7;
   localparam logic [7:0] OP_EXIT_WIDE_ADDR = 8'h29;
   localparam logic [5:0] CMD_CYC_SINGLE = 6'h08;
   localparam logic [5:0] CMD_CYC_QUAD = 6'h02;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [3:0] DUMMY_SINGLE_DEF = 4'h8;
   localparam logic [3:0] DUMMY_QUAD_DEF = 4'h6;
   localparam logic [3:0] FALLS_SINGLE = 4'h8;
   localparam logic [3:0] FALLS_QUAD = 4'h2;
   localparam logic [3:0] LANE_NONE = 4'h0;
   localparam logic [3:0] LANE_SINGLE_OUT = 4'h2;
   localparam logic [3:0] LANE_QUAD = 4'hF;
   localparam logic [1:0] SPACE_ARRAY = 2'h0;
   localparam logic [1:0] SPACE_UID = 2'h1;
   localparam logic [1:0] SPACE_INFO = 2'h2;
   localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
   localparam logic ADDR_WIDE_RST = 1'b0;
   localparam int ARRAY_AW = 26;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 32;
   // Synchronised pin vector: {io[3:0], chip select, sck}
   localparam int PIN_W = 7;
   localparam int PIN_SCK = 0;
   localparam int PIN_CSN = 1;
   localparam int PIN_IO = 2;
   localparam int PAUSE_LANE = 3;
   localparam logic [6:0] PIN_IDLE = 7'h7E;
   typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfr_state_t;
endpackage

// File: include/sfr_fifo_if.sv
// Interface: valid/ready byte stream between the read engine and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface sfr_fifo_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] inData;
   logic inValid;
   logic inReady;
   logic [WIDTH-1:0] outData;
   logic outValid;
   logic outReady;
   logic flush;
   modport fifo (input inData, inValid, outReady, flush, output inReady, outData, outValid);
   modport user (output inData, inValid, outReady, flush, input inReady, outData, outValid);
endinterface
`default_nettype wire

// File: core/sfr_byte_fifo.sv
// Byte FIFO with a registered output stage and bypass into it when empty
`timescale 1ns/1ps
`default_nettype none
module sfr_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rstn,
   sfr_fifo_if.fifo q
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;

   if (DEPTH < 2 || (1 << PW) != DEPTH)
   begin : g_depth_check
      $error("DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr, rdPtr;
   logic [CW-1:0] memCount;

   wire popOut = q.outValid & q.outReady;
   wire outFree = ~q.outValid | popOut;
   wire memEmpty = memCount == '0;
   wire push = q.inValid & q.inReady;
   wire loadFromMem = outFree & ~memEmpty;
   wire loadBypass = outFree & memEmpty & push;
   wire writeMem = push & ~loadBypass;

   assign q.inReady = memCount != CW'(DEPTH);

   always_ff @(posedge clk)
   begin
      if (!rstn || q.flush)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         memCount <= '0;
         q.outValid <= 1'b0;
      end
      else
      begin
         if (writeMem)
            wrPtr <= wrPtr + 1'b1;
         if (loadFromMem)
            rdPtr <= rdPtr + 1'b1;
         memCount <= memCount + CW'(writeMem) - CW'(loadFromMem);
         if (outFree)
            q.outValid <= ~memEmpty | push;
      end
   end

   always_ff @(posedge clk)
   begin
      if (writeMem)
         mem[wrPtr] <= q.inData;
   end

   // Read data always leaves through this register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         q.outData <= '0;
      else if (loadFromMem)
         q.outData <= mem[rdPtr];
      else if (loadBypass)
         q.outData <= q.inData;
   end
endmodule // sfr_byte_fifo
`default_nettype wire

// File: core/sfr_read_engine.sv
// Read command front end of a serial NOR flash: decode, address, dummy, data, pause
//
// Summary of operation
// R1: 03h takes 3/4 address bytes; 13h four
// R2: Decode A25-A0 wide, A23-A0 narrow
// R3: Serial input ignored after normal read address
// R4: Data out MSB first; address plus one per byte
// R5: Address counter wraps to zero past top
// R6: Chip select high ends output and command
// R7: Reads ignored while write in progress
// R8: 0Bh takes 3/4 bytes; 0Ch four; both modes
// R9: Single fast read: opcode, address, dummies sampled
// R10: Fast read data changes on falling SCK
// R11: Quad mode: 2 opcode, 6/8 address, 6 dummy
// R12: Quad mode data on four lines, falling edges
// R13: EBh, 4Bh, 68h use quad framing; ID/info narrow
// R14: Mode byte clocks count as dummy cycles
// R15: Pause acts only while selected, no reset
// R16: Host moves pause only while SCK low
// R17: Paused: output released, input ignored, then resume
// R18: Pause off in DTR, quad enable, reset pin
// R19: Normal read: no dummies, output on falling edge
// R20: Persistent address width set by host commands
`timescale 1ns/1ps
`default_nettype none
module sfr_read_engine #(
   parameter int ADDR_W = sfr_pkg::ARRAY_AW,
   parameter int DEPTH = sfr_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sckPin,
   input wire logic chipSelNPin,
   input wire logic [3:0] ioInPin,
   output logic [3:0] ioOut,
   output logic [3:0] ioOe,
   input wire logic quadCommandMode,
   input wire logic writeInProgressFlag,
   input wire logic quadEnableBit,
   input wire logic dtrMode,
   input wire logic pauseIsReset,
   input wire logic [3:0] dummySingle,
   input wire logic [3:0] dummyQuad,
   output logic addressWidthSelect,
   output logic readActive,
   output logic arrReq,
   output logic [ADDR_W-1:0] arrAddr,
   output logic [1:0] arrSpace,
   input wire logic [sfr_pkg::BYTE_W-1:0] arrData,
   input wire logic arrValid
);
   import sfr_pkg::*;

   if (ADDR_W < int'(ADDR_BITS_NARROW) || ADDR_W > int'(ADDR_BITS_WIDE))
   begin : g_addr_check
      $error("ADDR_W must lie between 24 and 32");
   end

   function automatic logic [ADDR_W-1:0] decodeAddr(input logic [31:0] a, input logic wide);
      logic [ADDR_W-1:0] r;
      r = a[ADDR_W-1:0];
      if (!wide)
         r = ADDR_W'(a[ADDR_BITS_NARROW-1:0]);
      return r;
   endfunction

   // Pin sampling: a change counts once the second and third stages agree
   logic [PIN_W-1:0] syncA, syncB, syncC, pinF;
   logic sckPrev, paused;
   wire [PIN_W-1:0] pinRaw = {ioInPin, chipSelNPin, sckPin};
   wire [PIN_W-1:0] agree = ~(syncB ^ syncC);
   wire [PIN_W-1:0] next_pinF = (agree & syncB) | (~agree & pinF);

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         syncA <= PIN_IDLE;
         syncB <= PIN_IDLE;
         syncC <= PIN_IDLE;
         pinF <= PIN_IDLE;
         sckPrev <= 1'b0;
      end
      else
      begin
         syncA <= pinRaw;
         syncB <= syncA;
         syncC <= syncB;
         pinF <= next_pinF;
         sckPrev <= pinF[PIN_SCK];
      end
   end

   wire sckNow = pinF[PIN_SCK];
   wire selN = pinF[PIN_CSN];
   wire [3:0] ioNow = pinF[PIN_IO +: 4];

   // Pause pin shares io3, so it cannot work while io3 carries data
   wire pauseAllowed = ~quadEnableBit & ~dtrMode & ~pauseIsReset & ~quadCommandMode; // R18
   wire next_paused = (selN | ~pauseAllowed) ? 1'b0 : (~sckNow ? ~ioNow[PAUSE_LANE] : paused); // R15 R16

   always_ff @(posedge clk)
   begin
      if (!rstn)
         paused <= 1'b0;
      else
         paused <= next_paused;
   end

   // Edges are swallowed while paused, which freezes the whole sequence
   wire rise = sckNow & ~sckPrev & ~paused & ~selN; // R17
   wire fall = ~sckNow & sckPrev & ~paused & ~selN; // R17

   sfr_state_t state;
   logic [5:0] cnt;
   logic [31:0] inShift;
   logic wide4, normal;
   logic [3:0] dummyLen;
   logic [1:0] space;

   wire [31:0] next_inShift = quadCommandMode ? {inShift[27:0], ioNow} : {inShift[30:0], ioNow[0]};
   wire [7:0] opcode = next_inShift[7:0];
   wire opNorm = ~quadCommandMode & (opcode == OP_NORMAL_READ | opcode == OP_NORMAL_READ_WIDE); // R1
   wire opFast = opcode == OP_FAST_READ | opcode == OP_FAST_READ_WIDE; // R8
   wire opQuadOnly = quadCommandMode & (opcode == OP_QUAD_IO_FAST_READ
      | opcode == OP_UNIQUE_ID_READ | opcode == OP_INFO_ROW_READ); // R13
   wire opRead = opNorm | opFast | opQuadOnly;
   wire opWide = opcode == OP_NORMAL_READ_WIDE | opcode == OP_FAST_READ_WIDE
      | (addressWidthSelect & (opcode == OP_NORMAL_READ | opcode == OP_FAST_READ
      | opcode == OP_QUAD_IO_FAST_READ)); // R1 R8 R13 R20
   wire [1:0] opSpace = opcode == OP_UNIQUE_ID_READ ? SPACE_UID
      : (opcode == OP_INFO_ROW_READ ? SPACE_INFO : SPACE_ARRAY);
   wire [3:0] dummyCfg = quadCommandMode
      ? (dummyQuad == 4'h0 ? DUMMY_QUAD_DEF : dummyQuad)
      : (dummySingle == 4'h0 ? DUMMY_SINGLE_DEF : dummySingle); // R9 R11

   wire [5:0] cmdCycles = quadCommandMode ? CMD_CYC_QUAD : CMD_CYC_SINGLE; // R9 R11
   wire [5:0] addrBits = wide4 ? ADDR_BITS_WIDE : ADDR_BITS_NARROW;
   wire [5:0] addrCycles = quadCommandMode ? (addrBits >> 2) : addrBits; // R11
   wire [5:0] phaseLen = state == ST_CMD ? cmdCycles
      : (state == ST_ADDR ? addrCycles : {2'h0, dummyLen});
   wire lastCycle = rise && cnt == phaseLen - 6'h01;
   wire cmdDone = state == ST_CMD && lastCycle;
   wire startFetch = state == ST_ADDR && lastCycle;
   wire [ADDR_W-1:0] startAddr = decodeAddr(next_inShift, wide4); // R2

   always_ff @(posedge clk)
   begin
      if (!rstn || selN) // R6
      begin
         state <= ST_IDLE;
         cnt <= 6'h00;
         inShift <= 32'h0;
         wide4 <= 1'b0;
         normal <= 1'b0;
         dummyLen <= 4'h0;
         space <= SPACE_ARRAY;
      end
      else
      begin
         if (rise && (state == ST_CMD || state == ST_ADDR))
            inShift <= next_inShift; // R3
         if (lastCycle)
            cnt <= 6'h00;
         else if (rise)
            cnt <= cnt + 6'h01;
         case (state)
            ST_IDLE: state <= ST_CMD;
            ST_CMD:
               if (cmdDone)
               begin
                  state <= (opRead && !writeInProgressFlag) ? ST_ADDR : ST_IGNORE; // R7
                  wide4 <= opWide & (opcode != OP_UNIQUE_ID_READ) & (opcode != OP_INFO_ROW_READ); // R13
                  normal <= opNorm;
                  dummyLen <= opNorm ? 4'h0 : dummyCfg; // R19
                  space <= opSpace;
               end
            ST_ADDR:
               if (lastCycle)
                  state <= dummyLen == 4'h0 ? ST_DATA : ST_DUMMY; // R19
            // Mode byte clocks are not decoded; they simply use up dummy clocks
            ST_DUMMY:
               if (lastCycle)
                  state <= ST_DATA; // R14
            ST_DATA, ST_IGNORE: state <= state;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Persistent width setting survives deselect; only the two commands move it
   always_ff @(posedge clk)
   begin
      if (!rstn)
         addressWidthSelect <= ADDR_WIDE_RST;
      else if (cmdDone && opcode == OP_ENTER_WIDE_ADDR)
         addressWidthSelect <= 1'b1; // R20
      else if (cmdDone && opcode == OP_EXIT_WIDE_ADDR)
         addressWidthSelect <= 1'b0; // R20
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         readActive <= 1'b0;
      else
         readActive <= state == ST_ADDR || state == ST_DUMMY || state == ST_DATA;
   end

   // Prefetch: one request in flight, stalled by a full FIFO
   sfr_fifo_if #(.WIDTH(BYTE_W)) fq ();
   sfr_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .q(fq)
   );

   logic fetching, reqPending;
   wire fetchGo = fetching & ~reqPending & ~arrReq & fq.inReady & ~selN;

   assign fq.inData = arrData;
   assign fq.inValid = arrValid & fetching & ~selN;
   assign fq.flush = selN;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         arrReq <= 1'b0;
         arrAddr <= '0;
         arrSpace <= SPACE_ARRAY;
         fetching <= 1'b0;
         reqPending <= 1'b0;
      end
      else
      begin
         arrReq <= startFetch | fetchGo;
         if (startFetch)
         begin
            arrAddr <= startAddr;
            arrSpace <= space;
         end
         else if (fetchGo)
            arrAddr <= arrAddr + 1'b1; // R4 R5
         if (selN)
            fetching <= 1'b0;
         else if (startFetch)
            fetching <= 1'b1;
         if (startFetch || fetchGo)
            reqPending <= 1'b1;
         else if (arrValid)
            reqPending <= 1'b0;
      end
   end

   // Output shifter: a new byte is taken from the FIFO on its first falling edge
   logic [7:0] outShift;
   logic [3:0] fallLeft;
   logic driving;
   wire dataFall = fall && state == ST_DATA;
   wire loadByte = dataFall && fallLeft == 4'h0;
   wire [3:0] fallsPerByte = quadCommandMode ? FALLS_QUAD : FALLS_SINGLE;
   wire [7:0] headByte = fq.outValid ? fq.outData : UNDERRUN_BYTE;
   wire [7:0] byteNow = loadByte ? headByte : outShift;
   wire [3:0] laneMask = quadCommandMode ? LANE_QUAD : LANE_SINGLE_OUT;

   assign fq.outReady = loadByte;

   always_ff @(posedge clk)
   begin
      if (!rstn || selN) // R6
      begin
         outShift <= 8'h00;
         fallLeft <= 4'h0;
         driving <= 1'b0;
         ioOut <= LANE_NONE;
      end
      else if (dataFall)
      begin
         driving <= 1'b1;
         ioOut <= quadCommandMode ? byteNow[7:4] : {2'h0, byteNow[7], 1'b0}; // R4 R10 R12
         outShift <= quadCommandMode ? {byteNow[3:0], 4'h0} : {byteNow[6:0], 1'b0};
         fallLeft <= (loadByte ? fallsPerByte : fallLeft) - 4'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         ioOe <= LANE_NONE;
      else
         ioOe <= (driving && !paused && !selN) ? laneMask : LANE_NONE; // R6 R17
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   deselect_quiet_a: // R6
      assert property (selN |=> ioOe == LANE_NONE)
      else $error("output enabled after deselect");
   pause_release_a: // R17
      assert property (paused |=> ioOe == LANE_NONE)
      else $error("output driven while paused");
   pause_freeze_a: // R15
      assert property (paused && !selN && $stable(selN) |=> $stable(cnt) && $stable(inShift))
      else $error("sequence moved while paused");
   pause_gate_a: // R18
      assert property (!pauseAllowed |=> !paused)
      else $error("pause taken while disabled");
   busy_ignore_a: // R7
      assert property (cmdDone && opRead && writeInProgressFlag |=> state == ST_IGNORE)
      else $error("read accepted during write in progress");
   addr_decode_a: // R2
      assert property (startFetch |=> arrReq && arrAddr == decodeAddr($past(next_inShift), wide4))
      else $error("start address decoded wrongly");
   addr_step_a: // R4
      assert property (arrReq && !$past(startFetch) |-> arrAddr == ADDR_W'($past(arrAddr) + 1'b1))
      else $error("address did not advance by one");
   lane_use_a: // R12
      assert property (ioOe != LANE_NONE |-> ioOe == laneMask && state == ST_DATA)
      else $error("wrong output lanes");
   normal_no_dummy_a: // R19
      assert property (startFetch && normal |=> state == ST_DATA)
      else $error("normal read entered dummy phase");
   cmd_length_a: // R11
      assert property (state == ST_CMD && rise |-> cnt < cmdCycles)
      else $error("opcode phase too long");
endmodule // sfr_read_engine
`default_nettype wire

// File: testbench/sfr_host_model.sv
// Host controller model: drives SCK, chip select and io lines, collects read bytes
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
   input var int halfNs,
   input wire logic [3:0] ioPin,
   input wire logic [3:0] ioOe,
   output logic sck,
   output logic csN,
   output logic [3:0] ioHost,
   output logic [3:0] ioHostOe,
   output logic [7:0] gotByte,
   output logic gotStb,
   output logic [3:0] pauseOe
);
   initial
   begin
      sck = 1'b0;
      csN = 1'b1;
      ioHost = 4'hF;
      ioHostOe = 4'h0;
      gotByte = 8'h00;
      gotStb = 1'b0;
      pauseOe = 4'h0;
   end
   task automatic half(input logic s);
      sck = s;
      #(halfNs);
   endtask
   // Pause pin moves only with SCK low; SCK keeps running during the pause
   task automatic hold(input int nTog);
      #(halfNs / 2) ioHost[3] = 1'b0;
      // Pause must clear the sampler before SCK moves, or one edge slips through
      #(halfNs / 2);
      repeat (nTog)
      begin
         half(1'b1);
         half(1'b0);
      end
      pauseOe = ioOe;
      ioHost[3] = 1'b1;
      #(halfNs);
   endtask
   // Data is sampled late, just before the next fall, to cover the sampler delay
   task automatic frame(input bit quad, input logic [7:0] op, input logic [31:0] a,
         input int nA, input int nD, input int nB, input int pz, input int nTog);
      int w;
      logic [39:0] sh;
      logic [7:0] b;
      w = quad ? 4 : 1;
      sh = {op, a << (32 - nA)};
      b = 8'h00;
      ioHostOe = quad ? 4'hF : 4'hD;
      csN = 1'b0;
      #(halfNs);
      for (int k = 0; k < (8 + nA) / w; k++)
      begin
         ioHost = quad ? sh[39:36] : {3'b111, sh[39]};
         sh = sh << w;
         half(1'b0);
         half(1'b1);
      end
      for (int k = 0; k < nD; k++)
      begin
         ioHost = (quad && k == 0) ? 4'hA : (4'($urandom) | {~quad, 3'b000});
         half(1'b0);
         half(1'b1);
      end
      ioHostOe = quad ? 4'h0 : 4'hD;
      for (int k = 0; k < nB * 8 / w; k++)
      begin
         // Garbage on the serial input must not disturb the stream
         ioHost = 4'($urandom) | 4'h8;
         half(1'b0);
         if (k == pz)
            hold(nTog);
         half(1'b1);
         b = quad ? {b[3:0], ioPin} : {b[6:0], ioPin[1]};
         if ((k + 1) % (8 / w) == 0)
         begin
            gotByte = b;
            gotStb = 1'b1;
            #1 gotStb = 1'b0;
         end
      end
      half(1'b0);
      csN = 1'b1;
      ioHostOe = 4'h0;
      #(2 * halfNs);
   endtask
endmodule // sfr_host_model
`default_nettype wire

// File: testbench/tb.sv
// Testbench: read engine driven by the host model, array answered locally
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sfr_pkg::*;
   logic clk, rstn, quadCommandMode, writeInProgressFlag, quadEnableBit, dtrMode;
   logic pauseIsReset, arrValid, addressWidthSelect, readActive, arrReq, sck, csN, gotStb;
   logic [3:0] dummySingle, dummyQuad, ioOut, ioOe, ioHost, ioHostOe, ioPin, pauseOe;
   logic [7:0] arrData, gotByte;
   logic [25:0] arrAddr;
   logic [1:0] arrSpace;
   int halfNs, n_mismatch, n_tests;
   logic expAct;
   logic [7:0] expQ[$];
   // Pull-ups on all four io lines
   assign ioPin = (ioOe & ioOut) | (~ioOe & ioHostOe & ioHost) | (~ioOe & ~ioHostOe);
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   sfr_read_engine sfr_read_engine_inst (.clk(clk), .rstn(rstn), .sckPin(sck),
      .chipSelNPin(csN), .ioInPin(ioPin), .ioOut(ioOut), .ioOe(ioOe),
      .quadCommandMode(quadCommandMode), .writeInProgressFlag(writeInProgressFlag),
      .quadEnableBit(quadEnableBit), .dtrMode(dtrMode), .pauseIsReset(pauseIsReset),
      .dummySingle(dummySingle), .dummyQuad(dummyQuad),
      .addressWidthSelect(addressWidthSelect), .readActive(readActive), .arrReq(arrReq),
      .arrAddr(arrAddr), .arrSpace(arrSpace), .arrData(arrData), .arrValid(arrValid));
   sfr_host_model sfr_host_model_inst (.halfNs(halfNs), .ioPin(ioPin), .ioOe(ioOe),
      .sck(sck), .csN(csN), .ioHost(ioHost), .ioHostOe(ioHostOe), .gotByte(gotByte),
      .gotStb(gotStb), .pauseOe(pauseOe));
   function automatic logic [7:0] mem(input logic [25:0] a, input logic [1:0] s);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ {4'h0, s, a[25:24]};
   endfunction
   always @(posedge clk)
   begin
      arrValid <= arrReq;
      arrData <= mem(arrAddr, arrSpace);
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   always @(posedge gotStb)
   begin
      chk("byte", expQ.size() != 0 ? {24'h0, expQ.pop_front()} : 32'hX, {24'h0, gotByte});
      chk("active", {31'h0, expAct}, {31'h0, readActive});
   end
   // A refused read leaves the lines released, so the host sees all ones
   task automatic rd(input bit quad, input logic [7:0] op, input logic [31:0] a, input int nA,
         input int nD, input int nB, input bit ok, input logic [1:0] s, input int pz = -1,
         input int nTog = 0);
      logic [25:0] p;
      p = (nA == 32) ? a[25:0] : {2'b00, a[23:0]};
      expAct = ok;
      for (int i = 0; i < nB; i++)
         expQ.push_back(ok ? mem(p + 26'(i), s) : 8'hFF);
      sfr_host_model_inst.frame(quad, op, a, nA, nD, nB, pz, nTog);
      chk("oe idle", 32'h0, {28'h0, ioOe});
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // The whole sequence needs well under a millisecond
   initial
   begin
      #1000000;
      n_mismatch++;
      conclude;
   end
   initial
   begin
      {rstn, quadCommandMode, writeInProgressFlag, quadEnableBit, dtrMode, pauseIsReset} = 6'h0;
      dummySingle = 4'h0;
      dummyQuad = 4'h0;
      halfNs = 100;
      n_mismatch = 0;
      n_tests = 0;
      void'($urandom(32'h4cda8f96));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk("rst", 32'h0, {ioOe, arrReq, readActive, addressWidthSelect});
      rd(0, OP_NORMAL_READ, 32'h0012_3456, 24, 0, 3, 1, SPACE_ARRAY);
      rd(0, OP_FAST_READ, 32'h00AB_CDEF, 24, 8, 2, 1, SPACE_ARRAY);
      rd(0, OP_NORMAL_READ_WIDE, 32'hFC00_0010, 32, 0, 2, 1, SPACE_ARRAY);
      rd(0, OP_FAST_READ_WIDE, 32'hFFFF_FFF0, 32, 8, 40, 1, SPACE_ARRAY);
      @(posedge clk) dummySingle <= 4'h5;
      rd(0, OP_FAST_READ, 32'h0000_7FFF, 24, 5, 2, 1, SPACE_ARRAY);
      @(posedge clk) dummySingle <= 4'h0;
      rd(0, OP_ENTER_WIDE_ADDR, 32'h0, 0, 0, 0, 1, SPACE_ARRAY);
      chk("width", 32'h1, {31'h0, addressWidthSelect});
      rd(0, OP_NORMAL_READ, 32'h0300_0007, 32, 0, 2, 1, SPACE_ARRAY);
      rd(0, OP_FAST_READ, 32'h0200_0100, 32, 8, 1, 1, SPACE_ARRAY);
      @(posedge clk) quadCommandMode <= 1'b1;
      rd(1, OP_QUAD_IO_FAST_READ, 32'h0155_AA01, 32, 6, 2, 1, SPACE_ARRAY);
      rd(1, OP_UNIQUE_ID_READ, 32'h0000_0004, 24, 6, 2, 1, SPACE_UID);
      rd(1, OP_INFO_ROW_READ, 32'h0000_0020, 24, 6, 1, 1, SPACE_INFO);
      rd(1, OP_FAST_READ_WIDE, 32'h4000_0ABC, 32, 6, 2, 1, SPACE_ARRAY);
      rd(1, OP_NORMAL_READ, 32'h0000_0100, 32, 0, 1, 0, SPACE_ARRAY);
      rd(1, OP_EXIT_WIDE_ADDR, 32'h0, 0, 0, 0, 1, SPACE_ARRAY);
      chk("width", 32'h0, {31'h0, addressWidthSelect});
      rd(1, OP_FAST_READ, 32'h00FF_FFFE, 24, 6, 2, 1, SPACE_ARRAY);
      @(posedge clk) dummyQuad <= 4'h4;
      rd(1, OP_FAST_READ, 32'h0012_0034, 24, 4, 2, 1, SPACE_ARRAY);
      @(posedge clk) writeInProgressFlag <= 1'b1;
      rd(1, OP_FAST_READ, 32'h0012_0034, 24, 4, 1, 0, SPACE_ARRAY);
      @(posedge clk) quadCommandMode <= 1'b0;
      rd(0, OP_NORMAL_READ, 32'h0000_0040, 24, 0, 1, 0, SPACE_ARRAY);
      rd(0, OP_FAST_READ, 32'h0000_0040, 24, 8, 1, 0, SPACE_ARRAY);
      @(posedge clk) writeInProgressFlag <= 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk) {quadEnableBit, dtrMode, pauseIsReset} <= 3'(8 >> (4 - i));
         rd(0, OP_NORMAL_READ, 32'h00F0_0F00 + i, 24, 0, 2, 1, SPACE_ARRAY, 11,
            i == 0 ? 3 : 0);
         chk("pause oe", i == 0 ? 32'h0 : 32'h2, {28'h0, pauseOe});
      end
      @(posedge clk) {quadEnableBit, dtrMode, pauseIsReset} <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
         halfNs = 100 + 100 * i;
         rd(0, i[0] ? OP_FAST_READ : OP_NORMAL_READ, $urandom, 24, i[0] ? 8 : 0, 3, 1,
            SPACE_ARRAY);
      end
      chk("left", 32'h0, expQ.size());
      conclude;
   end
endmodule // tb
`default_nettype wire
